// >>> verilog/dsad_pkg.sv
`default_nettype none
// shared constants for the data space address decoder
package dsad_pkg;
    // bus widths: word addresses, 16-bit words, 32-bit long words
    localparam int ADDR_W = 24;
    localparam int WORD_W = 16;
    localparam int LONG_W = 32;
    // data ram: words 000000..000FFF, held as 2K entries of 32 bits
    localparam logic [23:0] RAM_LO = 24'h000000;
    localparam logic [23:0] RAM_HI = 24'h000FFF;
    localparam int RAM_IDX_W = 11;
    // data flash array: words 001000..001FFF
    localparam logic [23:0] DFL_LO = 24'h001000;
    localparam logic [23:0] DFL_HI = 24'h001FFF;
    localparam int DFL_OFF_W = 12;
    // peripheral window: words 00F000..00FFFF, 4096 locations
    localparam logic [23:0] PER_LO = 24'h00F000;
    localparam logic [23:0] PER_HI = 24'h00FFFF;
    localparam int PER_OFF_W = 12;
    localparam logic [12:0] PER_WIN_END = 13'h1000;
    // debug window: top 256 words
    localparam logic [23:0] DBG_LO = 24'hFFFF00;
    localparam logic [23:0] DBG_HI = 24'hFFFFFF;
    localparam int DBG_OFF_W = 8;
    // flash configuration words at the top of program flash
    localparam logic [15:0] CFG_FIRST = 16'h3FF7;
    localparam logic [15:0] CFG_LAST = 16'h3FFF;
    localparam logic [3:0] CFG_WORDS = 4'h9;
    localparam logic [3:0] CFG_IDX_LAST = 4'h8;
    // peripheral bank bases, offsets inside the window, ascending
    localparam int PER_NUM = 20;
    localparam logic [11:0] PER_BASE [0:19] = '{
        12'h040, 12'h0C0, 12'h140, 12'h180, 12'h1A0,
        12'h200, 12'h270, 12'h280, 12'h290, 12'h2A0,
        12'h2B0, 12'h2C0, 12'h2D0, 12'h2E0, 12'h300,
        12'h310, 12'h350, 12'h360, 12'h400, 12'h800};
    // bank index of the first quad timer and of the flash controller
    localparam int PER_IDX_FIRST_TIMER = 0;
    localparam int PER_IDX_FLASH_CTRL = 18;
    // one-hot region code carried to the response stage
    typedef enum logic [4:0] {
        DSAD_R_NONE = 5'h01,
        DSAD_R_RAM = 5'h02,
        DSAD_R_DFL = 5'h04,
        DSAD_R_PER = 5'h08,
        DSAD_R_DBG = 5'h10
    } dsad_region_e;
    // configuration loader states
    typedef enum logic [2:0] {
        DSAD_CFG_LOAD = 3'h1,
        DSAD_CFG_WRITE = 3'h2,
        DSAD_CFG_DONE = 3'h4
    } dsad_cfg_e;
    // end of bank i inside the window (exclusive)
    function automatic logic [12:0] dsad_per_end(input int i);
        if (i + 1 < PER_NUM) begin
            return {1'b0, PER_BASE[i + 1]};
        end
        return PER_WIN_END;
    endfunction
endpackage
`default_nettype wire

// >>> verilog/dsad_per_decode.sv
`timescale 1ns/1ps
`default_nettype none
// picks one peripheral bank from an offset inside the peripheral window
module dsad_per_decode #(
    parameter int NUM_BANKS = dsad_pkg::PER_NUM
) (
    // offset inside the window
    input wire logic [11:0] win_off,
    // one-hot bank select and offset from that bank's base
    output logic [NUM_BANKS-1:0] bank_sel,
    output logic [11:0] bank_off,
    output logic bank_hit
);
    // running or of the masked per-bank offsets
    logic [11:0] off_chain [0:NUM_BANKS];

    assign off_chain[0] = 12'h000;

    // one comparator pair per bank; bases never overlap, so at most one hits
    for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
        localparam logic [12:0] LO = {1'b0, dsad_pkg::PER_BASE[i]};
        localparam logic [12:0] HI = dsad_pkg::dsad_per_end(i);
        // bank owns [LO, HI)
        assign bank_sel[i] = ({1'b0, win_off} >= LO) && ({1'b0, win_off} < HI); // see [RULE16]
        // offset relative to the bank base
        assign off_chain[i + 1] = off_chain[i] |
            (bank_sel[i] ? (win_off - dsad_pkg::PER_BASE[i]) : 12'h000); // see [RULE14]
    end

    // gap below the first base selects nothing
    assign bank_off = off_chain[NUM_BANKS];
    assign bank_hit = |bank_sel; // see [RULE15]
endmodule
`default_nettype wire

// >>> verilog/dsad_top.sv
// Notes on behaviour
// [RULE1] addresses are 16-bit word addresses
// [RULE2] words 000000-000FFF select data ram
// [RULE3] ram is 2K x 32, long word single cycle
// [RULE4] words 001000-001FFF select data flash
// [RULE5] no data flash variant: range selects nothing
// [RULE6] words 00F000-00FFFF select peripheral space
// [RULE7] top 256 words select debug registers
// [RULE8] master uses word accesses on peripherals
// [RULE9] program and boot flash share control bank
// [RULE10] data flash has its own control bank
// [RULE11] top nine program words configure flash controller
// [RULE12] init copies nine words into controller registers
// [RULE13] configuration words sit at 3FF7-3FFF
// [RULE14] first quad timer bank starts at 00F040
// [RULE15] reserved ranges select nothing, read zero
// [RULE16] exactly one peripheral select, offset passed
`timescale 1ns/1ps
`default_nettype none
module dsad_top #(
    parameter bit HAS_DATA_FLASH = 1'b1,
    parameter int NUM_BANKS = dsad_pkg::PER_NUM
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // core data request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [23:0] req_addr,
    input wire logic req_write,
    input wire logic req_long,
    input wire logic [31:0] req_wdata,
    // core read response
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    // data ram port
    output logic ram_en,
    output logic ram_we,
    output logic [10:0] ram_addr,
    output logic [1:0] ram_be,
    output logic [31:0] ram_wdata,
    input wire logic [31:0] ram_rdata,
    // data flash port
    output logic dfl_en,
    output logic dfl_we,
    output logic [11:0] dfl_addr,
    output logic [15:0] dfl_wdata,
    input wire logic [15:0] dfl_rdata,
    // peripheral banks
    output logic [NUM_BANKS-1:0] per_sel,
    output logic per_we,
    output logic [11:0] per_offset,
    output logic [15:0] per_wdata,
    input wire logic [15:0] per_rdata,
    // debug register window
    output logic dbg_en,
    output logic dbg_we,
    output logic [7:0] dbg_offset,
    output logic [15:0] dbg_wdata,
    input wire logic [15:0] dbg_rdata,
    // flash controller bank steering
    input wire logic prog_pflash_acc,
    input wire logic prog_boot_acc,
    output logic fc_prog_bank_sel,
    output logic fc_data_bank_sel,
    // configuration word read from program flash
    output logic cfg_rd_req,
    output logic [15:0] cfg_rd_addr,
    input wire logic cfg_rd_ack,
    input wire logic [15:0] cfg_rd_data,
    // configuration word write into controller registers
    output logic cfg_wr_en,
    output logic [3:0] cfg_wr_idx,
    output logic [15:0] cfg_wr_data,
    output logic init_done
);
    // request accepted this cycle
    logic acc;
    // region hits of the live request
    logic hit_ram;
    logic hit_dfl;
    logic hit_per;
    logic hit_dbg;
    // peripheral decoder outputs
    logic [NUM_BANKS-1:0] bank_sel;
    logic [11:0] bank_off;
    logic bank_hit;
    // stage one registers
    logic ram_en_reg;
    logic ram_we_reg;
    logic [10:0] ram_addr_reg;
    logic [1:0] ram_be_reg;
    logic [31:0] ram_wdata_reg;
    logic dfl_en_reg;
    logic dfl_we_reg;
    logic [11:0] dfl_addr_reg;
    logic [NUM_BANKS-1:0] per_sel_reg;
    logic per_we_reg;
    logic [11:0] per_offset_reg;
    logic dbg_en_reg;
    logic dbg_we_reg;
    logic [7:0] dbg_offset_reg;
    logic [15:0] wdata_reg;
    logic fc_prog_reg;
    logic fc_data_reg;
    // read tracking for the response stage
    logic rd_reg;
    logic long_reg;
    logic half_reg;
    dsad_pkg::dsad_region_e region_reg;
    dsad_pkg::dsad_region_e region_next;
    // response stage
    logic rsp_valid_reg;
    logic [31:0] rsp_rdata_reg;
    logic [31:0] rsp_rdata_next;
    // configuration loader
    dsad_pkg::dsad_cfg_e cfg_state_reg;
    logic [3:0] cfg_cnt_reg;
    logic [15:0] cfg_addr_reg;
    logic cfg_wr_en_reg;
    logic [15:0] cfg_data_reg;
    logic init_done_reg;

    // the core is held off until the configuration words are in place
    assign req_ready = init_done_reg;
    assign acc = req_valid && req_ready;

    // region compare on word addresses
    assign hit_ram = (req_addr <= dsad_pkg::RAM_HI); // see [RULE1] [RULE2]
    // the flash range only counts when the variant carries data flash
    assign hit_dfl = HAS_DATA_FLASH && (req_addr >= dsad_pkg::DFL_LO) &&
        (req_addr <= dsad_pkg::DFL_HI); // see [RULE4] [RULE5]
    // inside the window only a bank hit selects anything
    assign hit_per = (req_addr >= dsad_pkg::PER_LO) &&
        (req_addr <= dsad_pkg::PER_HI) && bank_hit; // see [RULE6]
    assign hit_dbg = (req_addr >= dsad_pkg::DBG_LO); // see [RULE7]

    // bank decode inside the peripheral window
    dsad_per_decode #(
        .NUM_BANKS(NUM_BANKS)
    ) u_per_decode (
        .win_off(req_addr[dsad_pkg::PER_OFF_W-1:0]),
        .bank_sel(bank_sel),
        .bank_off(bank_off),
        .bank_hit(bank_hit)
    );

    // region code of the live request; anything else is reserved
    always_comb begin
        region_next = dsad_pkg::DSAD_R_NONE; // see [RULE15]
        if (hit_ram) begin
            region_next = dsad_pkg::DSAD_R_RAM;
        end else if (hit_dfl) begin
            region_next = dsad_pkg::DSAD_R_DFL;
        end else if (hit_per) begin
            region_next = dsad_pkg::DSAD_R_PER;
        end else if (hit_dbg) begin
            region_next = dsad_pkg::DSAD_R_DBG;
        end
    end

    // ram strobes: one 32-bit entry holds two words
    always_ff @(posedge clk) begin
        if (rst) begin
            ram_en_reg <= 1'b0;
            ram_we_reg <= 1'b0;
            ram_addr_reg <= 11'h000;
            ram_be_reg <= 2'h0;
            ram_wdata_reg <= 32'h0000_0000;
        end else begin
            ram_en_reg <= acc && hit_ram;
            ram_we_reg <= acc && hit_ram && req_write;
            // word address bits above bit 0 pick the entry
            ram_addr_reg <= req_addr[dsad_pkg::RAM_IDX_W:1]; // see [RULE3]
            // long word: both halves in one cycle
            if (req_long) begin
                ram_be_reg <= 2'h3; // see [RULE3]
                ram_wdata_reg <= req_wdata;
            end else begin
                // bit 0 picks the half; word is copied to both lanes
                ram_be_reg <= req_addr[0] ? 2'h2 : 2'h1; // see [RULE1]
                ram_wdata_reg <= {req_wdata[15:0], req_wdata[15:0]};
            end
        end
    end

    // 16-bit targets: flash, peripherals, debug
    always_ff @(posedge clk) begin
        if (rst) begin
            dfl_en_reg <= 1'b0;
            dfl_we_reg <= 1'b0;
            dfl_addr_reg <= 12'h000;
            per_sel_reg <= '0;
            per_we_reg <= 1'b0;
            per_offset_reg <= 12'h000;
            dbg_en_reg <= 1'b0;
            dbg_we_reg <= 1'b0;
            dbg_offset_reg <= 8'h00;
            wdata_reg <= 16'h0000;
        end else begin
            dfl_en_reg <= acc && hit_dfl;
            dfl_we_reg <= acc && hit_dfl && req_write;
            dfl_addr_reg <= req_addr[dsad_pkg::DFL_OFF_W-1:0];
            // exactly one bank, with the offset from its base
            per_sel_reg <= (acc && hit_per) ? bank_sel : '0; // see [RULE16]
            per_we_reg <= acc && hit_per && req_write;
            per_offset_reg <= bank_off; // see [RULE14]
            dbg_en_reg <= acc && hit_dbg;
            dbg_we_reg <= acc && hit_dbg && req_write;
            dbg_offset_reg <= req_addr[dsad_pkg::DBG_OFF_W-1:0];
            // narrow targets take only the low word of a long access
            wdata_reg <= req_wdata[15:0]; // see [RULE8]
        end
    end

    // flash controller bank steering
    always_ff @(posedge clk) begin
        if (rst) begin
            fc_prog_reg <= 1'b0;
            fc_data_reg <= 1'b0;
        end else begin
            // program, boot and configuration reads all use one bank
            fc_prog_reg <= prog_pflash_acc || prog_boot_acc ||
                (cfg_state_reg == dsad_pkg::DSAD_CFG_LOAD); // see [RULE9]
            // data flash accesses use the other bank
            fc_data_reg <= acc && hit_dfl; // see [RULE10]
        end
    end

    // remember what a read needs for its answer
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_reg <= 1'b0;
            long_reg <= 1'b0;
            half_reg <= 1'b0;
            region_reg <= dsad_pkg::DSAD_R_NONE;
        end else begin
            rd_reg <= acc && !req_write;
            long_reg <= req_long;
            half_reg <= req_addr[0];
            region_reg <= region_next;
        end
    end

    // answer mux; reserved space reads as zero
    always_comb begin
        rsp_rdata_next = 32'h0000_0000;
        unique case (region_reg)
            dsad_pkg::DSAD_R_NONE: begin
                rsp_rdata_next = 32'h0000_0000; // see [RULE15]
            end
            dsad_pkg::DSAD_R_RAM: begin
                if (long_reg) begin
                    rsp_rdata_next = ram_rdata; // see [RULE3]
                end else if (half_reg) begin
                    rsp_rdata_next = {16'h0000, ram_rdata[31:16]};
                end else begin
                    rsp_rdata_next = {16'h0000, ram_rdata[15:0]};
                end
            end
            dsad_pkg::DSAD_R_DFL: begin
                rsp_rdata_next = {16'h0000, dfl_rdata};
            end
            dsad_pkg::DSAD_R_PER: begin
                rsp_rdata_next = {16'h0000, per_rdata};
            end
            dsad_pkg::DSAD_R_DBG: begin
                rsp_rdata_next = {16'h0000, dbg_rdata};
            end
            default: begin
                rsp_rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // response register, two cycles after acceptance
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= 32'h0000_0000;
        end else begin
            rsp_valid_reg <= rd_reg;
            rsp_rdata_reg <= rd_reg ? rsp_rdata_next : 32'h0000_0000;
        end
    end

    // configuration loader: read a word, write it, step, nine times
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_state_reg <= dsad_pkg::DSAD_CFG_LOAD;
        end else begin
            unique case (cfg_state_reg)
                dsad_pkg::DSAD_CFG_LOAD: begin
                    if (cfg_rd_ack) begin
                        cfg_state_reg <= dsad_pkg::DSAD_CFG_WRITE;
                    end
                end
                dsad_pkg::DSAD_CFG_WRITE: begin
                    // stop after the ninth word
                    if (cfg_cnt_reg == dsad_pkg::CFG_IDX_LAST) begin
                        cfg_state_reg <= dsad_pkg::DSAD_CFG_DONE; // see [RULE11]
                    end else begin
                        cfg_state_reg <= dsad_pkg::DSAD_CFG_LOAD;
                    end
                end
                dsad_pkg::DSAD_CFG_DONE: begin
                    cfg_state_reg <= dsad_pkg::DSAD_CFG_DONE;
                end
                default: begin
                    cfg_state_reg <= dsad_pkg::DSAD_CFG_LOAD;
                end
            endcase
        end
    end

    // loader index, address and write strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_cnt_reg <= 4'h0;
            cfg_addr_reg <= dsad_pkg::CFG_FIRST; // see [RULE13]
            cfg_wr_en_reg <= 1'b0;
            cfg_data_reg <= 16'h0000;
            init_done_reg <= 1'b0;
        end else begin
            // copy the word just read into the matching register
            cfg_wr_en_reg <= (cfg_state_reg == dsad_pkg::DSAD_CFG_LOAD) && cfg_rd_ack; // see [RULE12]
            if ((cfg_state_reg == dsad_pkg::DSAD_CFG_LOAD) && cfg_rd_ack) begin
                cfg_data_reg <= cfg_rd_data;
            end
            if (cfg_state_reg == dsad_pkg::DSAD_CFG_WRITE) begin
                if (cfg_cnt_reg == dsad_pkg::CFG_IDX_LAST) begin
                    init_done_reg <= 1'b1;
                end else begin
                    cfg_cnt_reg <= cfg_cnt_reg + 4'h1;
                    cfg_addr_reg <= cfg_addr_reg + 16'h0001; // see [RULE13]
                end
            end
        end
    end

    // outputs
    assign ram_en = ram_en_reg;
    assign ram_we = ram_we_reg;
    assign ram_addr = ram_addr_reg;
    assign ram_be = ram_be_reg;
    assign ram_wdata = ram_wdata_reg;
    assign dfl_en = dfl_en_reg;
    assign dfl_we = dfl_we_reg;
    assign dfl_addr = dfl_addr_reg;
    assign dfl_wdata = wdata_reg;
    assign per_sel = per_sel_reg;
    assign per_we = per_we_reg;
    assign per_offset = per_offset_reg;
    assign per_wdata = wdata_reg;
    assign dbg_en = dbg_en_reg;
    assign dbg_we = dbg_we_reg;
    assign dbg_offset = dbg_offset_reg;
    assign dbg_wdata = wdata_reg;
    assign fc_prog_bank_sel = fc_prog_reg;
    assign fc_data_bank_sel = fc_data_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rsp_rdata_reg;
    assign cfg_rd_req = (cfg_state_reg == dsad_pkg::DSAD_CFG_LOAD);
    assign cfg_rd_addr = cfg_addr_reg;
    assign cfg_wr_en = cfg_wr_en_reg;
    assign cfg_wr_idx = cfg_cnt_reg;
    assign cfg_wr_data = cfg_data_reg;
    assign init_done = init_done_reg;

    // helper: configuration writes seen so far
    logic [3:0] chk_wr_cnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            chk_wr_cnt <= 4'h0;
        end else if (cfg_wr_en_reg) begin
            chk_wr_cnt <= chk_wr_cnt + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ram_select_a: assert property (acc && req_addr <= 24'h000FFF |=> // see [RULE2]
        ram_en && ram_addr == $past(req_addr[11:1]))
        else $error("ram not selected for ram address");
    word_lane_a: assert property (acc && hit_ram && !req_long |=> // see [RULE1]
        ram_be == ($past(req_addr[0]) ? 2'h2 : 2'h1))
        else $error("word access drove wrong ram half");
    ram_long_a: assert property (acc && hit_ram && req_long && !req_write ##1 1'b1 |=> // see [RULE3]
        rsp_valid && rsp_rdata == $past(ram_rdata))
        else $error("long ram read not returned whole");
    dflash_select_a: assert property (acc && req_addr >= 24'h001000 && req_addr <= 24'h001FFF |=> // see [RULE4]
        dfl_en == HAS_DATA_FLASH && fc_data_bank_sel == HAS_DATA_FLASH)
        else $error("data flash select mismatch");
    debug_select_a: assert property (acc && req_addr >= 24'hFFFF00 |=> // see [RULE7]
        dbg_en && dbg_offset == $past(req_addr[7:0]))
        else $error("debug window not selected");
    per_onehot_a: assert property ($onehot0(per_sel) && (!per_we || $onehot(per_sel))) // see [RULE16]
        else $error("peripheral select not one-hot");
    timer_bank_a: assert property (acc && req_addr >= 24'h00F040 && req_addr < 24'h00F0C0 |=> // see [RULE14]
        per_sel[0] && per_offset == $past(req_addr[11:0]) - 12'h040)
        else $error("first timer bank decode wrong");
    reserved_none_a: assert property (acc && !req_write && region_next == dsad_pkg::DSAD_R_NONE |=> // see [RULE15]
        !(ram_en || dfl_en || dbg_en || |per_sel) ##1 rsp_valid && rsp_rdata == 32'h0)
        else $error("reserved access selected a target or read nonzero");
    cfg_range_a: assert property (cfg_rd_req |-> // see [RULE13]
        cfg_rd_addr >= 16'h3FF7 && cfg_rd_addr <= 16'h3FFF && cfg_rd_addr - 16'h3FF7 == {12'h000, cfg_cnt_reg})
        else $error("configuration read outside the top nine words");
    cfg_count_a: assert property ($rose(init_done) |-> // see [RULE11] [RULE12]
        chk_wr_cnt == 4'h9 && $past(cfg_wr_idx) == 4'h8)
        else $error("wrong number of configuration words copied");

    long_ram_c: cover property (acc && hit_ram && req_long);
    timer_hit_c: cover property (acc && hit_per && bank_sel[0]);
    reserved_rd_c: cover property (acc && !req_write && region_next == dsad_pkg::DSAD_R_NONE);
    init_done_c: cover property ($rose(init_done));
endmodule
`default_nettype wire

// >>> bench/dsad_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: program flash config source and the four data targets
module dsad_far_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // config word source
    input wire logic cfg_rd_req,
    input wire logic [15:0] cfg_rd_addr,
    output logic cfg_rd_ack,
    output logic [15:0] cfg_rd_data,
    // target strobes
    input wire logic ram_en,
    input wire logic [10:0] ram_addr,
    input wire logic dfl_en,
    input wire logic [11:0] dfl_addr,
    input wire logic [19:0] per_sel,
    input wire logic [11:0] per_offset,
    input wire logic dbg_en,
    input wire logic [7:0] dbg_offset,
    // target read data
    output logic [31:0] ram_rdata,
    output logic [15:0] dfl_rdata,
    output logic [15:0] per_rdata,
    output logic [15:0] dbg_rdata
);
    logic [1:0] dly = 2'h1; // idle cycles before the next ack
    logic tog = 1'b0; // filler that changes every cycle on idle buses
    int n = 0; // ack count, varies the delay
    initial cfg_rd_ack = 1'b0;
    // one-cycle ack after 0..2 cycles, so both prompt and slow answers occur
    always @(posedge clk) begin
        #1;
        tog = ~tog;
        if (rst || cfg_rd_ack) begin
            cfg_rd_ack = 1'b0;
            n++;
            dly = 2'(n % 3);
        end else if (cfg_rd_req) begin
            if (dly == 2'h0) cfg_rd_ack = 1'b1;
            else dly--;
        end
    end
    // words are a fixed function of their address; idle buses toggle
    assign cfg_rd_data = cfg_rd_ack ? (cfg_rd_addr ^ 16'h5A00) : {16{tog}};
    assign ram_rdata = ram_en ? {5'h1A, ram_addr, 5'h05, ram_addr} : {32{tog}};
    assign dfl_rdata = dfl_en ? {4'h3, dfl_addr} : {16{tog}};
    assign per_rdata = (|per_sel) ? {per_sel[3:0], per_offset} : {16{tog}};
    assign dbg_rdata = dbg_en ? {8'hD0, dbg_offset} : {16{tog}};
endmodule
`default_nettype wire

// >>> bench/dsad_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module dsad_top_test;
    // design nets
    logic clk = 0, rst = 1, req_valid = 0, req_write = 0, req_long = 0, prog_pflash_acc = 0, prog_boot_acc = 0;
    logic [23:0] req_addr = 0;
    logic [31:0] req_wdata = 0, rsp_rdata, ram_wdata, ram_rdata;
    logic req_ready, rsp_valid, ram_en, ram_we, dfl_en, dfl_we, per_we, dbg_en, dbg_we, init_done;
    logic fc_prog_bank_sel, fc_data_bank_sel, cfg_rd_req, cfg_rd_ack, cfg_wr_en;
    logic [10:0] ram_addr;
    logic [1:0] ram_be;
    logic [11:0] dfl_addr, per_offset;
    logic [15:0] dfl_wdata, dfl_rdata, per_wdata, per_rdata, dbg_wdata, dbg_rdata, cfg_rd_addr, cfg_rd_data, cfg_wr_data;
    logic [19:0] per_sel;
    logic [7:0] dbg_offset;
    logic [3:0] cfg_wr_idx;
    // bench model state: stage 1 strobes, stage 2 answer
    int fails = 0, checked = 0, cycles = 0, seed = 47, wc = 0, a1 = 0, k, g;
    logic v1 = 0, w1, l1, rd2 = 0, ackd = 0, rdy = 0, pexp = 0;
    logic [31:0] d1, e2;
    // address ranges picked at random: targets, then reserved holes
    int lo [7] = '{'h0, 'h1000, 'hF000, 'hFFFF00, 'h2000, 'h10000, 'hF000};
    int span [7] = '{'h1000, 'h1000, 'h1000, 'h100, 'hD000, 'hFEFF00, 'h40};
    dsad_top uut (.clk, .rst, .req_valid, .req_ready, .req_addr, .req_write, .req_long, .req_wdata, .rsp_valid,
        .rsp_rdata, .ram_en, .ram_we, .ram_addr, .ram_be, .ram_wdata, .ram_rdata, .dfl_en, .dfl_we, .dfl_addr,
        .dfl_wdata, .dfl_rdata, .per_sel, .per_we, .per_offset, .per_wdata, .per_rdata, .dbg_en, .dbg_we,
        .dbg_offset, .dbg_wdata, .dbg_rdata, .prog_pflash_acc, .prog_boot_acc, .fc_prog_bank_sel,
        .fc_data_bank_sel, .cfg_rd_req, .cfg_rd_addr, .cfg_rd_ack, .cfg_rd_data, .cfg_wr_en, .cfg_wr_idx,
        .cfg_wr_data, .init_done);
    dsad_far_model far (.clk, .rst, .cfg_rd_req, .cfg_rd_addr, .cfg_rd_ack, .cfg_rd_data, .ram_en, .ram_addr,
        .dfl_en, .dfl_addr, .per_sel, .per_offset, .dbg_en, .dbg_offset, .ram_rdata, .dfl_rdata, .per_rdata,
        .dbg_rdata);
    always #2.5 clk = ~clk;
    // region: 0 ram, 1 data flash, 2 peripheral bank, 3 debug, 4 nothing
    function automatic int region(int a);
        if (a <= 'hFFF) return 0;
        if (a <= 'h1FFF) return 1;
        if (a >= 'hF040 && a <= 'hFFFF) return 2;
        if (a >= 'hFFFF00) return 3;
        return 4;
    endfunction
    // last bank whose base lies at or below the offset
    function automatic int bank(int off);
        bank = 0;
        for (int i = 0; i < 20; i++) if (off >= dsad_pkg::PER_BASE[i]) bank = i;
    endfunction
    // read answer expected at the core for an address
    function automatic logic [31:0] rdexp(int a, logic lng);
        logic [31:0] f;
        f = {5'h1A, a[11:1], 5'h05, a[11:1]};
        case (region(a))
            0: return lng ? f : (a[0] ? {16'h0, f[31:16]} : {16'h0, f[15:0]});
            1: return {16'h0, 4'h3, a[11:0]};
            2: return {16'h0, 4'(1 << bank(a - 'hF000)), 12'(a - 'hF000 - dsad_pkg::PER_BASE[bank(a - 'hF000)])};
            3: return {16'h0, 8'hD0, a[7:0]};
            default: return 32'h0;
        endcase
    endfunction
    // model: take requests, track the config load, cut hangs short
    always @(posedge clk) begin
        cycles++;
        // loader reads from reset release until done, except in each write cycle
        pexp = !rst && (prog_pflash_acc || prog_boot_acc || (!rdy && !ackd));
        if (rst) begin
            v1 = 0;
            rd2 = 0;
            ackd = 0;
            rdy = 0;
            wc = 0;
        end else begin
            rd2 = v1 && !w1;
            e2 = rdexp(a1, l1);
            v1 = req_valid && rdy;
            a1 = req_addr;
            w1 = req_write;
            l1 = req_long;
            d1 = req_wdata;
            if (ackd) begin
                if (wc == 8) rdy = 1;
                wc++;
            end
            ackd = cfg_rd_ack && cfg_rd_req;
            if (ackd) `CMP(cfg_rd_addr, 16'(16'h3FF7 + wc))
        end
        if (cycles > 4000) begin
            fails++;
            tally_and_finish;
        end
    end
    // compare every settled output with the model
    always @(negedge clk) if (!rst) begin
        int r;
        int o;
        r = region(a1);
        o = a1 - 'hF000;
        `CMP({ram_en, dfl_en, dbg_en, fc_data_bank_sel}, {v1 && r == 0, v1 && r == 1, v1 && r == 3, v1 && r == 1})
        `CMP(per_sel, (v1 && r == 2) ? 20'(1 << bank(o)) : 20'h0)
        if (v1 && r == 0) `CMP({ram_we, ram_addr, ram_be, ram_wdata}, {w1, a1[11:1], l1 ? 2'h3 : (a1[0] ? 2'h2 : 2'h1), l1 ? d1 : {2{d1[15:0]}}})
        if (v1 && r == 2) `CMP({per_we, per_offset, per_wdata}, {w1, 12'(o - dsad_pkg::PER_BASE[bank(o)]), d1[15:0]})
        if (v1 && r == 1) `CMP({dfl_we, dfl_addr, dfl_wdata}, {w1, a1[11:0], d1[15:0]})
        if (v1 && r == 3) `CMP({dbg_we, dbg_offset, dbg_wdata}, {w1, a1[7:0], d1[15:0]})
        `CMP({rsp_valid, rsp_rdata}, {rd2, rd2 ? e2 : 32'h0})
        `CMP({init_done, req_ready, fc_prog_bank_sel, cfg_wr_en, cfg_rd_req}, {rdy, rdy, pexp, ackd, !rdy && !ackd})
        if (ackd) `CMP({cfg_wr_idx, cfg_wr_data}, {4'(wc), 16'(16'h3FF7 + wc) ^ 16'h5A00})
    end
    // one random request, mixing boundaries and reserved holes
    task automatic drive;
        k = {$random(seed)} % 7;
        g = {$random(seed)} % 4;
        req_addr = 24'(lo[k] + (g == 0 ? 0 : (g == 1 ? span[k] - 1 : {$random(seed)} % span[k])));
        req_valid = ($random(seed) & 7) != 0;
        req_write = 1'($random(seed));
        req_long = region(req_addr) != 2 && 1'($random(seed));
        req_wdata = $random(seed);
        {prog_pflash_acc, prog_boot_acc} = 2'($random(seed));
    endtask
    // print counts and verdict, then stop
    task automatic tally_and_finish;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // requests during the load must be refused, then back-to-back traffic
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 0;
        while (!rdy) begin
            @(posedge clk);
            #1 drive();
        end
        $display("test config load done");
        repeat (1500) begin
            @(posedge clk);
            #1 drive();
        end
        @(posedge clk);
        #1 req_valid = 0;
        repeat (3) @(posedge clk);
        $display("test traffic done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
